//--- design/ftd_pkg.sv
package ftd_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int FTD_SAMP_W = 14;
  localparam int FTD_THR_W = 13;
  localparam int FTD_DWELL_W = 16;
  localparam int FTD_CNT_W = 17;
  localparam int FTD_IDX_W = 10;
  localparam int FTD_ADDR_W = 12;
  localparam int FTD_IRQ_W = 4;
  localparam int FTD_HI_W = FTD_THR_W - 8;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int FTD_CLK_NS = 50;
  localparam int FTD_SET_MAX_CYC = 28;
  localparam int FTD_LOW_DLY = 2;
  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_UPPER_LO = 10'h247;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_UPPER_HI = 10'h248;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_LOWER_LO = 10'h249;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_LOWER_HI = 10'h24a;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_DWELL_LO = 10'h24b;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_DWELL_HI = 10'h24c;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_IRQ_STATUS = 10'h250;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_IRQ_CLEAR = 10'h251;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_IRQ_ENABLE = 10'h252;
  localparam logic [FTD_IDX_W-1:0] FTD_IDX_DETECT = 10'h253;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FTD_RST_UPPER_LO = 8'hff;
  localparam logic [FTD_HI_W-1:0] FTD_RST_UPPER_HI = 5'h1f;
  localparam logic [7:0] FTD_RST_LOWER_LO = 8'h00;
  localparam logic [FTD_HI_W-1:0] FTD_RST_LOWER_HI = 5'h00;
  localparam logic [7:0] FTD_RST_DWELL_LO = 8'h01;
  localparam logic [7:0] FTD_RST_DWELL_HI = 8'h00;
  // ---------------------------------------------------------------
  // Interrupt bit positions and bus answers
  // ---------------------------------------------------------------
  localparam int FTD_IRQ_RISE_A = 0;
  localparam int FTD_IRQ_RISE_B = 1;
  localparam int FTD_IRQ_FALL_A = 2;
  localparam int FTD_IRQ_FALL_B = 3;
  localparam logic [1:0] FTD_RESP_OKAY = 2'h0;
  localparam logic [1:0] FTD_RESP_SLVERR = 2'h2;
endpackage : ftd_pkg

//--- design/ftd_chan.sv
`timescale 1ns/100ps
module ftd_chan
  import ftd_pkg::*;
#(
  parameter int LOW_DLY = FTD_LOW_DLY
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [FTD_SAMP_W-1:0] sample,
  input wire logic [FTD_THR_W-1:0] upper,
  input wire logic [FTD_THR_W-1:0] lower,
  input wire logic [FTD_DWELL_W-1:0] dwell,
  output logic threshold_flag
);
  // ---------------------------------------------------------------
  // Magnitude and compares
  // ---------------------------------------------------------------
  logic [FTD_SAMP_W-1:0] mag_ff;
  logic [FTD_SAMP_W-1:0] nxt_mag;
  logic [FTD_SAMP_W-1:0] dly_ff [LOW_DLY];
  logic [FTD_CNT_W-1:0] cnt_ff;
  logic [FTD_DWELL_W-1:0] eff_dwell;
  logic flag_ff;
  logic hi_now;
  logic low_now;
  logic clr_ok;

  // Full scale magnitude is 2^13, one above the largest code
  always_comb begin
    nxt_mag = sample[FTD_SAMP_W-1] ? FTD_SAMP_W'(-sample) : sample;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mag_ff <= '0;
    end else begin
      mag_ff <= nxt_mag;
    end
  end

  // Lower path sees the longer pipeline, no bits dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LOW_DLY; i++) begin
        dly_ff[i] <= '0;
      end
    end else begin
      dly_ff[0] <= mag_ff;
      for (int i = 1; i < LOW_DLY; i++) begin
        dly_ff[i] <= dly_ff[i-1];
      end
    end
  end

  assign hi_now = mag_ff > {1'b0, upper};
  assign low_now = dly_ff[LOW_DLY-1] < {1'b0, lower};
  // Zero dwell would clear on the first low sample; treat it as one
  assign eff_dwell = (dwell == '0) ? FTD_DWELL_W'(1) : dwell;
  assign clr_ok = low_now && (cnt_ff >= {1'b0, eff_dwell});

  // ---------------------------------------------------------------
  // Dwell counter, saturating
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (!low_now) begin
      cnt_ff <= '0;
    end else if (cnt_ff != '1) begin
      cnt_ff <= cnt_ff + FTD_CNT_W'(1);
    end
  end

  // Set beats clear so a new peak is never masked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= 1'b0;
    end else if (hi_now) begin
      flag_ff <= 1'b1;
    end else if (flag_ff && clr_ok) begin
      flag_ff <= 1'b0;
    end
  end

  assign threshold_flag = flag_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cross_up;
    (sample[FTD_SAMP_W-1] ? FTD_SAMP_W'(-sample) : sample) > {1'b0, upper} && $stable(upper);
  endsequence

  sequence s_flag_seen;
    ##[1:2] flag_ff;
  endsequence

  set_latency_a: assert property (s_cross_up |-> ##1 $stable(upper) ##0 s_flag_seen)
    else $error("flag late after upper crossing");
  set_fast_a: assert property (hi_now |=> flag_ff)
    else $error("flag not set above upper threshold");
  clear_dwell_a: assert property ($fell(flag_ff) |-> $past(cnt_ff) >= {1'b0, $past(eff_dwell)})
    else $error("flag cleared before dwell ran out");
  hold_high_a: assert property (flag_ff && !low_now |=> flag_ff)
    else $error("flag cleared without low sample");
  restart_cnt_a: assert property (!low_now |=> cnt_ff == '0)
    else $error("dwell count not restarted");
  lower_delay_a: assert property (##LOW_DLY dly_ff[LOW_DLY-1] == $past(mag_ff, LOW_DLY))
    else $error("lower path delay wrong");
endmodule : ftd_chan

//--- design/ftd_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ftd_top
  import ftd_pkg::*;
#(
  parameter int LOW_DLY = FTD_LOW_DLY
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [FTD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [FTD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [FTD_SAMP_W-1:0] sample_a,
  input wire logic [FTD_SAMP_W-1:0] sample_b,
  output logic detect_out_chan_a,
  output logic detect_out_chan_b,
  output logic irq
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic aw_got_ff;
  logic w_got_ff;
  logic [FTD_IDX_W-1:0] wr_idx_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic wr_byte;
  logic [FTD_IDX_W-1:0] rd_idx;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] upper_lo_ff;
  logic [FTD_HI_W-1:0] upper_hi_ff;
  logic [7:0] lower_lo_ff;
  logic [FTD_HI_W-1:0] lower_hi_ff;
  logic [7:0] dwell_lo_ff;
  logic [7:0] dwell_hi_ff;
  logic [FTD_THR_W-1:0] upper_val;
  logic [FTD_THR_W-1:0] lower_val;
  logic [FTD_DWELL_W-1:0] dwell_val;
  logic [FTD_IRQ_W-1:0] status_ff;
  logic [FTD_IRQ_W-1:0] nxt_status;
  logic [FTD_IRQ_W-1:0] enable_ff;
  logic [FTD_IRQ_W-1:0] clr_mask;
  logic [FTD_IRQ_W-1:0] events;
  logic [1:0] det_now;
  logic [1:0] det_q_ff;

  function automatic logic is_mapped(input logic [FTD_IDX_W-1:0] idx);
    is_mapped = (idx >= FTD_IDX_UPPER_LO && idx <= FTD_IDX_DWELL_HI) ||
                (idx >= FTD_IDX_IRQ_STATUS && idx <= FTD_IDX_DETECT);
  endfunction : is_mapped

  // ---------------------------------------------------------------
  // Write channels, address and data taken in either order
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_byte = do_write && wstrb0_ff;
  assign wr_hit = is_mapped(wr_idx_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      wr_idx_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      wr_idx_ff <= s_axi_awaddr[FTD_ADDR_W-1:2];
    end else if (do_write) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= FTD_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? FTD_RESP_OKAY : FTD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ---------------------------------------------------------------
  // Threshold and dwell registers
  // ---------------------------------------------------------------
  // Only byte lane 0 carries data; other lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_lo_ff <= FTD_RST_UPPER_LO;
      upper_hi_ff <= FTD_RST_UPPER_HI;
      lower_lo_ff <= FTD_RST_LOWER_LO;
      lower_hi_ff <= FTD_RST_LOWER_HI;
      dwell_lo_ff <= FTD_RST_DWELL_LO;
      dwell_hi_ff <= FTD_RST_DWELL_HI;
    end else if (wr_byte) begin
      unique case (wr_idx_ff)
        FTD_IDX_UPPER_LO: upper_lo_ff <= wdata_ff[7:0];
        FTD_IDX_UPPER_HI: upper_hi_ff <= wdata_ff[FTD_HI_W-1:0];
        FTD_IDX_LOWER_LO: lower_lo_ff <= wdata_ff[7:0];
        FTD_IDX_LOWER_HI: lower_hi_ff <= wdata_ff[FTD_HI_W-1:0];
        FTD_IDX_DWELL_LO: dwell_lo_ff <= wdata_ff[7:0];
        FTD_IDX_DWELL_HI: dwell_hi_ff <= wdata_ff[7:0];
        default: begin
        end
      endcase
    end
  end

  // Pairs take effect byte by byte; software writes both halves
  assign upper_val = {upper_hi_ff, upper_lo_ff};
  assign lower_val = {lower_hi_ff, lower_lo_ff};
  assign dwell_val = {dwell_hi_ff, dwell_lo_ff};

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  ftd_chan #(
    .LOW_DLY(LOW_DLY)
  ) u_chan_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample(sample_a),
    .upper(upper_val),
    .lower(lower_val),
    .dwell(dwell_val),
    .threshold_flag(det_now[0])
  );

  ftd_chan #(
    .LOW_DLY(LOW_DLY)
  ) u_chan_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample(sample_b),
    .upper(upper_val),
    .lower(lower_val),
    .dwell(dwell_val),
    .threshold_flag(det_now[1])
  );

  assign detect_out_chan_a = det_now[0];
  assign detect_out_chan_b = det_now[1];

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_q_ff <= '0;
    end else begin
      det_q_ff <= det_now;
    end
  end

  always_comb begin
    events = '0;
    events[FTD_IRQ_RISE_A] = det_now[0] && !det_q_ff[0];
    events[FTD_IRQ_RISE_B] = det_now[1] && !det_q_ff[1];
    events[FTD_IRQ_FALL_A] = !det_now[0] && det_q_ff[0];
    events[FTD_IRQ_FALL_B] = !det_now[1] && det_q_ff[1];
  end

  assign clr_mask = (wr_byte && wr_idx_ff == FTD_IDX_IRQ_CLEAR) ?
                    wdata_ff[FTD_IRQ_W-1:0] : '0;
  // Event in the clearing cycle survives the clear
  assign nxt_status = (status_ff & ~clr_mask) | events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_ff <= '0;
    end else if (wr_byte && wr_idx_ff == FTD_IDX_IRQ_ENABLE) begin
      enable_ff <= wdata_ff[FTD_IRQ_W-1:0];
    end
  end

  assign irq = |(status_ff & enable_ff);

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign rd_idx = s_axi_araddr[FTD_ADDR_W-1:2];
  assign rd_hit = is_mapped(rd_idx);

  always_comb begin
    rd_val = '0;
    unique case (rd_idx)
      FTD_IDX_UPPER_LO: rd_val[7:0] = upper_lo_ff;
      FTD_IDX_UPPER_HI: rd_val[FTD_HI_W-1:0] = upper_hi_ff;
      FTD_IDX_LOWER_LO: rd_val[7:0] = lower_lo_ff;
      FTD_IDX_LOWER_HI: rd_val[FTD_HI_W-1:0] = lower_hi_ff;
      FTD_IDX_DWELL_LO: rd_val[7:0] = dwell_lo_ff;
      FTD_IDX_DWELL_HI: rd_val[7:0] = dwell_hi_ff;
      FTD_IDX_IRQ_STATUS: rd_val[FTD_IRQ_W-1:0] = status_ff;
      FTD_IDX_IRQ_ENABLE: rd_val[FTD_IRQ_W-1:0] = enable_ff;
      FTD_IDX_DETECT: rd_val[1:0] = det_now;
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= FTD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_hit ? FTD_RESP_OKAY : FTD_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Channel a magnitude rebuilt from the pin, not taken from the channel
  logic [FTD_SAMP_W-1:0] mag_a;
  assign mag_a = sample_a[FTD_SAMP_W-1] ? FTD_SAMP_W'(-sample_a) : sample_a;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_upper_lo_write;
    wr_byte && wr_idx_ff == FTD_IDX_UPPER_LO;
  endsequence

  sequence s_upper_hi_write;
    wr_byte && wr_idx_ff == FTD_IDX_UPPER_HI;
  endsequence

  upper_lo_write_a: assert property (s_upper_lo_write |=> upper_val[7:0] == $past(wdata_ff[7:0]))
    else $error("upper low byte not in low bits");
  upper_hi_write_a: assert property (s_upper_hi_write |=>
      upper_val[FTD_THR_W-1:8] == $past(wdata_ff[FTD_HI_W-1:0]))
    else $error("upper high bits not in top bits");
  dwell_hi_write_a: assert property (wr_byte && wr_idx_ff == FTD_IDX_DWELL_HI |=>
      dwell_val[15:8] == $past(wdata_ff[7:0]))
    else $error("dwell high byte misplaced");
  lower_lo_write_a: assert property (wr_byte && wr_idx_ff == FTD_IDX_LOWER_LO |=>
      lower_val[7:0] == $past(wdata_ff[7:0]))
    else $error("lower low byte misplaced");
  chan_split_a: assert property ($rose(det_now[0]) |->
      $past(mag_a, 2) > {1'b0, $past(upper_val)})
    else $error("detect a rose without a crossing on a");
  set_wins_a: assert property (events[FTD_IRQ_RISE_A] |=> status_ff[FTD_IRQ_RISE_A])
    else $error("rise event lost");
  status_sticky_a: assert property (status_ff[0] && clr_mask[0] == 1'b0 |=> status_ff[0])
    else $error("status bit dropped");
  resp_after_both_a: assert property ($rose(bvalid_ff) |-> $past(aw_got_ff && w_got_ff))
    else $error("write answered early");
  rvalid_hold_a: assert property (rvalid_ff && !s_axi_rready |=> rvalid_ff && $stable(rdata_ff))
    else $error("read data dropped");
  bvalid_hold_a: assert property (bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write answer dropped");
endmodule : ftd_top

//--- tb/ftd_agc_model.sv
`timescale 1ns/100ps
module ftd_agc_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic det_a,
  input wire logic det_b,
  output logic [7:0] cuts_a,
  output logic [7:0] cuts_b
);
  // ---------------------------------------------------------------
  // Gain cut requests, one per detect rise, pins watched apart
  // ---------------------------------------------------------------
  logic prev_a_ff;
  logic prev_b_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_a_ff <= 1'b0;
      prev_b_ff <= 1'b0;
      cuts_a <= 8'h00;
      cuts_b <= 8'h00;
    end else begin
      prev_a_ff <= det_a;
      prev_b_ff <= det_b;
      // Counters wrap; a run never holds 256 rises
      if (det_a && !prev_a_ff) cuts_a <= cuts_a + 8'h01;
      if (det_b && !prev_b_ff) cuts_b <= cuts_b + 8'h01;
    end
  end
endmodule : ftd_agc_model

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import ftd_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int LD = 2;
  localparam int D = 5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [FTD_ADDR_W-1:0] awaddr = '0;
  logic [FTD_ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, da, db, irq;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic [FTD_SAMP_W-1:0] sa = '0;
  logic [FTD_SAMP_W-1:0] sb = '0;
  logic [7:0] cuts_a, cuts_b;
  int err_total = 0;
  int compares = 0;
  ftd_top #(.LOW_DLY(LD)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_a(sa), .sample_b(sb), .detect_out_chan_a(da), .detect_out_chan_b(db),
    .irq(irq));
  ftd_agc_model u_agc (.aclk(aclk), .aresetn(aresetn), .det_a(da), .det_b(db),
    .cuts_a(cuts_a), .cuts_b(cuts_b));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [9:0] i, input logic [7:0] d, output logic [1:0] r);
    bit a;
    bit w;
    a = 0;
    w = 0;
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Either channel may be taken first
    // No wait limit here; the watchdog ends a hung transfer
    while (!(a && w)) begin
      @(posedge aclk);
      if (awready && !a) begin a = 1; awvalid <= 1'b0; end
      if (wready && !w) begin w = 1; wvalid <= 1'b0; end
    end
    do begin @(posedge aclk); end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [9:0] i, output logic [31:0] d, output logic [1:0] r);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge aclk); end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin @(posedge aclk); end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic w(input logic [9:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr(i, d, r);
  endtask : w
  task automatic rc(input logic [9:0] i, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(d, e, m);
  endtask : rc
  // Cycles until the pin reaches v, 200 means it never did
  task automatic wait_det(input bit ch, input logic v, output int n);
    n = 0;
    while (n < 200 && (ch ? db : da) !== v) begin @(posedge aclk); n++; end
  endtask : wait_det
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    int n;
    rc(FTD_IDX_UPPER_LO, 32'hff, "upper lo reset");
    rc(FTD_IDX_UPPER_HI, 32'h1f, "upper hi reset");
    rc(FTD_IDX_LOWER_LO, 32'h00, "lower lo reset");
    rc(FTD_IDX_LOWER_HI, 32'h00, "lower hi reset");
    rc(FTD_IDX_DWELL_LO, 32'h01, "dwell lo reset");
    rc(FTD_IDX_DWELL_HI, 32'h00, "dwell hi reset");
    // Max positive 8191 sits at the reset threshold, full scale 8192 above it
    sa <= 14'h1fff;
    repeat (40) @(posedge aclk);
    chk({31'h0, da}, 32'h0, "max positive flagged");
    sa <= 14'h2000;
    wait_det(0, 1'b1, n);
    chk({31'h0, n <= FTD_SET_MAX_CYC}, 32'h1, "full scale not flagged");
    sa <= 14'h0000;
  endtask : t_reset
  task automatic t_regs();
    logic [1:0] r;
    logic [31:0] d;
    wr(FTD_IDX_UPPER_HI, 8'hff, r);
    chk({30'h0, r}, 32'h0, "write resp");
    rc(FTD_IDX_UPPER_HI, 32'h1f, "upper hi width");
    wr(10'h3ff, 8'h5a, r);
    chk({30'h0, r}, {30'h0, FTD_RESP_SLVERR}, "unmapped write resp");
    rd(10'h3ff, d, r);
    chk({30'h0, r}, {30'h0, FTD_RESP_SLVERR}, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    w(FTD_IDX_DWELL_HI, 8'hab);
    w(FTD_IDX_DWELL_LO, 8'hcd);
    rc(FTD_IDX_DWELL_HI, 32'hab, "dwell hi");
    rc(FTD_IDX_DWELL_LO, 32'hcd, "dwell lo");
    // Byte lane 0 disabled, the register must keep its value
    wstrb <= 4'h0;
    w(FTD_IDX_DWELL_LO, 8'h11);
    wstrb <= 4'hf;
    rc(FTD_IDX_DWELL_LO, 32'hcd, "masked write landed");
    // Thresholds 0x1000 and 0x0800, dwell D, split over byte pairs
    w(FTD_IDX_UPPER_LO, 8'h00);
    w(FTD_IDX_UPPER_HI, 8'h10);
    w(FTD_IDX_LOWER_LO, 8'h00);
    w(FTD_IDX_LOWER_HI, 8'h08);
    w(FTD_IDX_DWELL_HI, 8'h00);
    w(FTD_IDX_DWELL_LO, D[7:0]);
    repeat (50) @(posedge aclk);
  endtask : t_regs
  task automatic t_set();
    int n;
    chk({31'h0, da}, 32'h0, "a not cleared");
    sa <= 14'h1000;
    repeat (40) @(posedge aclk);
    chk({31'h0, da}, 32'h0, "equal flagged");
    sa <= 14'h2fff;
    wait_det(0, 1'b1, n);
    chk({31'h0, n <= FTD_SET_MAX_CYC}, 32'h1, "negative set late");
    chk({31'h0, db}, 32'h0, "b follows a");
    rc(FTD_IDX_DETECT, 32'h1, "detect state");
    sb <= 14'h1001;
    wait_det(1, 1'b1, n);
    chk({31'h0, n <= FTD_SET_MAX_CYC}, 32'h1, "b set late");
    sb <= 14'h0000;
  endtask : t_set
  task automatic t_dwell();
    int n;
    sa <= 14'h0100;
    wait_det(0, 1'b0, n);
    chk({31'h0, n >= D + LD + 1}, 32'h1, "cleared early");
    chk({31'h0, n <= D + LD + 4}, 32'h1, "cleared late");
  endtask : t_dwell
  task automatic t_restart();
    int n;
    sa <= 14'h1800;
    wait_det(0, 1'b1, n);
    sa <= 14'h0100;
    repeat (D) @(posedge aclk);
    // Equal to the lower code is not below it
    sa <= 14'h0800;
    @(posedge aclk);
    sa <= 14'h0100;
    repeat (D) @(posedge aclk);
    chk({31'h0, da}, 32'h1, "broken run cleared");
    wait_det(0, 1'b0, n);
    chk({31'h0, n <= D + LD + 4}, 32'h1, "no clear after run");
  endtask : t_restart
  task automatic t_irq();
    repeat (20) @(posedge aclk);
    rc(FTD_IDX_IRQ_STATUS, 32'hf, "status events");
    chk({31'h0, irq}, 32'h0, "masked irq");
    w(FTD_IDX_IRQ_ENABLE, 8'h04);
    chk({31'h0, irq}, 32'h1, "enabled irq");
    w(FTD_IDX_IRQ_CLEAR, 8'h0f);
    rc(FTD_IDX_IRQ_STATUS, 32'h0, "status clear");
    chk({31'h0, irq}, 32'h0, "irq after clear");
    chk({24'h0, cuts_a}, 32'h3, "a rises");
    chk({24'h0, cuts_b}, 32'h1, "b rises");
  endtask : t_irq
  // ---------------------------------------------------------------
  // Run
  // ---------------------------------------------------------------
  initial begin
    forever #(FTD_CLK_NS / 2) aclk = ~aclk;
  end
  // Whole run is a few hundred cycles; this is many times that
  initial begin
    #(FTD_CLK_NS * 20000);
    err_total++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_set();
    t_dwell();
    t_restart();
    t_irq();
    test_done();
  end
endmodule : testbench
